/* File: design/adx_dma_ctrl.sv */
// control, status and sequencing of the converter-to-data-RAM transfer engine
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - any enabled event raises the transfer interrupt pending output.
// - operations-complete flag, control bit 6, sets when engine returns idle other than by a stop write.
// - converter B overflow error, control bit 4, on result lost.
// - converter A overflow error, control bit 3, on result lost.
// - warning flags bit 1 (B) and bit 0 (A) when buffer still full.
// - control bit 2 gates warning flags onto the interrupt.
// - repeat overflow flag config bit 2; interrupts only with config bit 3.
// - end-of-operation flag config bit 0; interrupts only with config bit 1.
// - event flags are sticky; only software writing zero clears them.
// - finished result enters an empty internal buffer at once.
// - buffer goes to RAM first chance; no new result until drained.
// - third result before drain overwrites held word and flags error.
// - control bit 7 write starts or stops; read shows running.
// - control bit 5 selects sequencing mode 0 or mode 1.
// - config bit 7 at 1 gives off-chip RAM to CPU; engine holds writes.
// - config bit 6 reads 1 while engine accesses off-chip RAM.
// - 6-bit instruction pointer increments after each data port access.
// - instruction bits: 7 continuous, 6 differential, 5 B, 4 A.
// - continuous bit in end-of-operation ignores repeat counter, runs on.
// - instruction buffer contents need no reset.
// - 6-bit boundary register gives the starting instruction address.
// - instruction buffer holds 64 words of 8 bits.
// - data pointer loads begin address at start, advances 2 per word.
// - mode 0 end-of-operation rewinds, decrements counter, stops at zero.
// - mode 1 repeats each instruction until zero, then reloads and advances.
module adx_dma_ctrl (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic        SFR_WR,
   input  wire logic        SFR_RD,
   input  wire logic [7:0]  SFR_WDATA,
   output logic      [7:0]  SFR_RDATA,
   input  wire logic        ADC_A_DONE,
   input  wire logic [15:0] ADC_A_DATA,
   input  wire logic        ADC_B_DONE,
   input  wire logic [15:0] ADC_B_DATA,
   output logic             RAM_WR_REQ,
   output logic             RAM_OFFCHIP,
   output logic      [15:0] RAM_ADDR,
   output logic      [15:0] RAM_WDATA,
   input  wire logic        RAM_WR_ACK,
   output logic             DMA_IRQ
);
   import adx_pkg::*;

   adx_state_e             st_q;
   adx_state_e             st_d;
   logic [7:0]             instr_q;
   logic [ADX_IADDR_W-1:0] iptr_q, isw_q, bnd_q;
   logic [15:0]            begin_q, dptr_q, limit_q, rpt_q;
   logic                   mode_q, warnen_q, grant_q, rpten_q, eoen_q;
   logic                   done_f_q, rpt_f_q, eo_f_q;
   logic [1:0]             err_q, warn_q;
   logic [1:0]             full_q, pend_q, drain, cnv_done;
   logic [1:0]             err_set, warn_set;
   logic [15:0]            buf_q  [2];
   logic [15:0]            hold_q [2];
   logic [15:0]            cnv_data [2];
   logic [7:0]             rdata_q, mem_rdata;
   logic                   idt_rd_q;
   logic                   wr_cn, wr_cf, idt_acc, start_wr, stop_wr;
   logic                   running, offchip, wr_ok, word_ack;
   logic                   eop, step_wrap, done_set, rpt_set, eo_set;
   logic [15:0]            rpt_dec;

   //////////////////////////////////////////////////////////////////////////
   // register access decode
   assign wr_cn    = SFR_WR && SFR_ADDR == ADX_A_CONTROL;
   assign wr_cf    = SFR_WR && SFR_ADDR == ADX_A_CONFIG;
   assign idt_acc  = (SFR_WR || SFR_RD) && SFR_ADDR == ADX_A_IDATA;
   assign start_wr = wr_cn && SFR_WDATA[ADX_CN_RUN];
   assign stop_wr  = wr_cn && !SFR_WDATA[ADX_CN_RUN];
   assign running  = st_q != ADX_IDLE;
   assign cnv_done = {ADC_B_DONE, ADC_A_DONE};
   assign cnv_data[0] = ADC_A_DATA;
   assign cnv_data[1] = ADC_B_DATA;

   // instruction buffer: the register port wins over fetches
   adx_ibuf #(
      .WORDS  (ADX_IBUF_WORDS),
      .ADDR_W (ADX_IADDR_W)
   ) u_ibuf (
      .CLK   (CLK),
      .WE    (SFR_WR && SFR_ADDR == ADX_A_IDATA),
      .ADDR  (idt_acc ? iptr_q : isw_q),
      .WDATA (SFR_WDATA),
      .RDATA (mem_rdata)
   );

   // instruction pointer steps after every data port access
   always_ff @(posedge CLK) begin
      if (RST) begin
         iptr_q <= ADX_IADDR_W'(ADX_RST_BYTE);
      end else if (SFR_WR && SFR_ADDR == ADX_A_IPTR) begin
         iptr_q <= SFR_WDATA[ADX_IADDR_W-1:0];
      end else if (idt_acc) begin
         iptr_q <= iptr_q + 1'b1;
      end
   end

   // plain read/write settings
   always_ff @(posedge CLK) begin
      if (RST) begin
         bnd_q   <= ADX_IADDR_W'(ADX_RST_BYTE);
         begin_q <= ADX_RST_WORD;
         limit_q <= ADX_RST_WORD;
         mode_q  <= 1'b0;
         warnen_q <= 1'b0;
         grant_q <= 1'b0;
         rpten_q <= 1'b0;
         eoen_q  <= 1'b0;
      end else if (SFR_WR) begin
         unique case (SFR_ADDR)
            ADX_A_BOUNDARY: bnd_q <= SFR_WDATA[ADX_IADDR_W-1:0];
            ADX_A_BEGIN_LO: begin_q[7:0] <= SFR_WDATA;
            ADX_A_BEGIN_HI: begin_q[15:8] <= SFR_WDATA;
            ADX_A_LIMIT_LO: limit_q[7:0] <= SFR_WDATA;
            ADX_A_LIMIT_HI: limit_q[15:8] <= SFR_WDATA;
            ADX_A_CONTROL: begin
               mode_q   <= SFR_WDATA[ADX_CN_MODE];
               warnen_q <= SFR_WDATA[ADX_CN_WARNEN];
            end
            ADX_A_CONFIG: begin
               grant_q <= SFR_WDATA[ADX_CF_GRANT];
               rpten_q <= SFR_WDATA[ADX_CF_RPTEN];
               eoen_q  <= SFR_WDATA[ADX_CF_EOEN];
            end
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // per-converter double buffering: internal buffer plus held result
   for (genvar c = 0; c < 2; c++) begin : g_cnv
      logic arrive;
      assign arrive      = cnv_done[c] && running;
      // a full buffer that is not draining this cycle cannot take the word
      assign warn_set[c] = arrive && full_q[c] && !drain[c] && !pend_q[c];
      assign err_set[c]  = arrive && full_q[c] && !drain[c] && pend_q[c];

      always_ff @(posedge CLK) begin
         if (RST) begin
            full_q[c] <= 1'b0;
            pend_q[c] <= 1'b0;
            buf_q[c]  <= ADX_RST_WORD;
            hold_q[c] <= ADX_RST_WORD;
         end else begin
            if (drain[c]) begin
               buf_q[c]  <= hold_q[c];
               full_q[c] <= pend_q[c];
               pend_q[c] <= 1'b0;
            end
            if (arrive) begin
               if (!full_q[c] || (drain[c] && !pend_q[c])) begin
                  buf_q[c]  <= cnv_data[c];
                  full_q[c] <= 1'b1;
               end else begin
                  hold_q[c] <= cnv_data[c];
                  pend_q[c] <= 1'b1;
               end
            end
         end
      end

      // sticky flags; a set in the clearing cycle wins
      always_ff @(posedge CLK) begin
         if (RST) begin
            err_q[c]  <= 1'b0;
            warn_q[c] <= 1'b0;
         end else begin
            if (err_set[c]) begin
               err_q[c] <= 1'b1;
            end else if (wr_cn) begin
               err_q[c] <= SFR_WDATA[ADX_CN_ERR_A+c];
            end
            if (warn_set[c]) begin
               warn_q[c] <= 1'b1;
            end else if (wr_cn) begin
               warn_q[c] <= SFR_WDATA[ADX_CN_WARN_A+c];
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // RAM write port: off-chip words wait while the CPU holds the grant
   assign offchip     = dptr_q >= ADX_ONCHIP_TOP;
   assign wr_ok       = !(offchip && grant_q);
   assign RAM_WR_REQ  = ((st_q == ADX_WR_A && full_q[0]) ||
                         (st_q == ADX_WR_B && full_q[1])) && wr_ok;
   assign word_ack    = RAM_WR_REQ && RAM_WR_ACK;
   assign drain[0]    = word_ack && st_q == ADX_WR_A;
   assign drain[1]    = word_ack && st_q == ADX_WR_B;
   assign RAM_OFFCHIP = offchip;
   assign RAM_ADDR    = dptr_q;
   assign RAM_WDATA   = (st_q == ADX_WR_B) ? buf_q[1] : buf_q[0];

   // sequencing decisions
   assign eop       = instr_q[ADX_I_DIFF:ADX_I_A] == 3'b000;
   assign rpt_dec   = rpt_q - 16'h0001;
   assign step_wrap = rpt_dec == ADX_RST_WORD;
   assign done_set  = running && st_d == ADX_IDLE && !stop_wr;
   assign eo_set    = st_q == ADX_STEP && eop;
   assign rpt_set   = st_q == ADX_STEP && step_wrap &&
                      (mode_q ? !eop : (eop && !instr_q[ADX_I_CONT]));

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ADX_IDLE:   if (start_wr) st_d = ADX_FETCH;
         ADX_FETCH:  if (!idt_acc) st_d = ADX_DECODE;
         ADX_DECODE: begin
            // with differential and A both set one A word goes out, plus a B word if B is set
            if (mem_rdata[ADX_I_DIFF] || mem_rdata[ADX_I_A]) begin
               st_d = ADX_WR_A;
            end else if (mem_rdata[ADX_I_B]) begin
               st_d = ADX_WR_B;
            end else begin
               st_d = ADX_STEP;
            end
         end
         ADX_WR_A: if (drain[0]) begin
            st_d = instr_q[ADX_I_B] ? ADX_WR_B : ADX_STEP;
         end
         ADX_WR_B: if (drain[1]) st_d = ADX_STEP;
         ADX_STEP: begin
            st_d = ADX_FETCH;
            if (eop && !instr_q[ADX_I_CONT] && (mode_q || step_wrap)) begin
               st_d = ADX_IDLE;
            end
         end
         default: st_d = ADX_IDLE;
      endcase
      if (stop_wr) st_d = ADX_IDLE;
      else if (start_wr && !running) st_d = ADX_FETCH;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ADX_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // instruction latch, addresses and repeat counter
   always_ff @(posedge CLK) begin
      if (RST) begin
         instr_q <= ADX_RST_BYTE;
         isw_q   <= ADX_IADDR_W'(ADX_RST_BYTE);
         dptr_q  <= ADX_RST_WORD;
         rpt_q   <= ADX_RST_WORD;
      end else if (start_wr && !running) begin
         isw_q  <= bnd_q;
         dptr_q <= begin_q;
         rpt_q  <= limit_q;
      end else begin
         if (st_q == ADX_DECODE) instr_q <= mem_rdata;
         if (word_ack) dptr_q <= dptr_q + ADX_STEP_WORD;
         if (SFR_WR && SFR_ADDR == ADX_A_PTR_LO) dptr_q[7:0] <= SFR_WDATA;
         if (SFR_WR && SFR_ADDR == ADX_A_PTR_HI) dptr_q[15:8] <= SFR_WDATA;
         if (st_q == ADX_STEP) begin
            if (eop) begin
               isw_q <= bnd_q;
               // continuous run leaves the counter alone
               if (!mode_q && !instr_q[ADX_I_CONT]) begin
                  rpt_q <= rpt_dec;
               end
            end else if (!mode_q) begin
               isw_q <= isw_q + 1'b1;
            end else if (step_wrap) begin
               rpt_q <= limit_q;
               isw_q <= isw_q + 1'b1;
            end else begin
               rpt_q <= rpt_dec;
            end
         end
      end
   end

   // completion, repeat and end-of-operation flags
   always_ff @(posedge CLK) begin
      if (RST) begin
         done_f_q <= 1'b0;
         rpt_f_q  <= 1'b0;
         eo_f_q   <= 1'b0;
      end else begin
         if (done_set) done_f_q <= 1'b1;
         else if (wr_cn) done_f_q <= SFR_WDATA[ADX_CN_DONE];
         if (rpt_set) rpt_f_q <= 1'b1;
         else if (wr_cf) rpt_f_q <= SFR_WDATA[ADX_CF_RPT];
         if (eo_set) eo_f_q <= 1'b1;
         else if (wr_cf) eo_f_q <= SFR_WDATA[ADX_CF_EO];
      end
   end

   // interrupt pending: level while any enabled flag stands
   assign DMA_IRQ = done_f_q || (|err_q) ||
                    (warnen_q && (|warn_q)) ||
                    (rpten_q && rpt_f_q) ||
                    (eoen_q && eo_f_q);

   //////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the read strobe
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_q  <= ADX_RST_BYTE;
         idt_rd_q <= 1'b0;
      end else begin
         idt_rd_q <= SFR_RD && SFR_ADDR == ADX_A_IDATA;
         if (SFR_RD) begin
            unique case (SFR_ADDR)
               ADX_A_CONTROL: rdata_q <= {running, done_f_q, mode_q,
                  err_q[1], err_q[0], warnen_q, warn_q[1], warn_q[0]};
               ADX_A_CONFIG:  rdata_q <= {grant_q,
                  RAM_WR_REQ && offchip, 2'b00, rpten_q,
                  rpt_f_q, eoen_q, eo_f_q};
               ADX_A_IPTR:     rdata_q <= {2'b00, iptr_q};
               ADX_A_BOUNDARY: rdata_q <= {2'b00, bnd_q};
               ADX_A_CUR_ADDR: rdata_q <= {2'b00, isw_q};
               ADX_A_BEGIN_LO: rdata_q <= begin_q[7:0];
               ADX_A_BEGIN_HI: rdata_q <= begin_q[15:8];
               ADX_A_PTR_LO:   rdata_q <= dptr_q[7:0];
               ADX_A_PTR_HI:   rdata_q <= dptr_q[15:8];
               ADX_A_LIMIT_LO: rdata_q <= limit_q[7:0];
               ADX_A_LIMIT_HI: rdata_q <= limit_q[15:8];
               ADX_A_COUNT_LO: rdata_q <= rpt_q[7:0];
               ADX_A_COUNT_HI: rdata_q <= rpt_q[15:8];
               default:        rdata_q <= ADX_RST_BYTE;
            endcase
         end
      end
   end
   assign SFR_RDATA = idt_rd_q ? mem_rdata : rdata_q;

   //////////////////////////////////////////////////////////////////////////
   // checks
   irq_eo_gate_a: assert property (@(posedge CLK) disable iff (RST)
      eo_f_q && eoen_q |-> DMA_IRQ) else $error("end-of-op irq missing");
   irq_warn_off_a: assert property (@(posedge CLK) disable iff (RST)
      !warnen_q && !done_f_q && err_q == 2'b00 && !(rpten_q && rpt_f_q)
      && !(eoen_q && eo_f_q) |-> !DMA_IRQ)
      else $error("warning irq not gated");
   done_flag_a: assert property (@(posedge CLK) disable iff (RST)
      running && st_d == ADX_IDLE && !stop_wr |=> done_f_q && !running)
      else $error("complete flag not set");
   err_a_a: assert property (@(posedge CLK) disable iff (RST)
      err_set[0] |=> err_q[0] && pend_q[0]) else $error("A error lost");
   err_b_a: assert property (@(posedge CLK) disable iff (RST)
      err_set[1] |=> err_q[1] && DMA_IRQ) else $error("B error lost");
   warn_flag_a: assert property (@(posedge CLK) disable iff (RST)
      warn_set[0] |=> warn_q[0] && pend_q[0]) else $error("warning lost");
   sticky_a: assert property (@(posedge CLK) disable iff (RST)
      $fell(err_q[1]) || $fell(done_f_q) |-> $past(wr_cn))
      else $error("flag cleared by hardware");
   iptr_step_a: assert property (@(posedge CLK) disable iff (RST)
      idt_acc |=> iptr_q == $past(iptr_q) + 1'b1)
      else $error("pointer did not step");
   start_load_a: assert property (@(posedge CLK) disable iff (RST)
      start_wr && !running |=> isw_q == $past(bnd_q)
      && dptr_q == $past(begin_q) && running) else $error("start load");
   hold_off_a: assert property (@(posedge CLK) disable iff (RST)
      grant_q && offchip |-> !RAM_WR_REQ) else $error("write while held");
   ack_step_a: assert property (@(posedge CLK) disable iff (RST)
      word_ack && !start_wr |=> dptr_q == $past(dptr_q) + ADX_STEP_WORD)
      else $error("data pointer step");
   cv_start_c: cover property (@(posedge CLK) start_wr ##[1:50] word_ack);
   cv_eop_c:   cover property (@(posedge CLK) eo_set ##1 !running);
   cv_err_c:   cover property (@(posedge CLK) warn_set[0] ##[1:20] err_set[0]);
   cv_rpt_c:   cover property (@(posedge CLK) rpt_set && mode_q);
endmodule

/* File: design/adx_pkg.sv */
// shared constants for the converter-to-data-RAM transfer controller
package adx_pkg;
   // special function register addresses
   localparam logic [7:0] ADX_A_CONTROL    = 8'hD8;
   localparam logic [7:0] ADX_A_BEGIN_LO   = 8'hD9;
   localparam logic [7:0] ADX_A_BEGIN_HI   = 8'hDA;
   localparam logic [7:0] ADX_A_PTR_LO     = 8'hDB;
   localparam logic [7:0] ADX_A_PTR_HI     = 8'hDC;
   localparam logic [7:0] ADX_A_IPTR       = 8'hDD;
   localparam logic [7:0] ADX_A_IDATA      = 8'hDE;
   localparam logic [7:0] ADX_A_CONFIG     = 8'hF8;
   localparam logic [7:0] ADX_A_LIMIT_LO   = 8'hF9;
   localparam logic [7:0] ADX_A_LIMIT_HI   = 8'hFA;
   localparam logic [7:0] ADX_A_COUNT_LO   = 8'hFB;
   localparam logic [7:0] ADX_A_COUNT_HI   = 8'hFC;
   localparam logic [7:0] ADX_A_BOUNDARY   = 8'hFD;
   localparam logic [7:0] ADX_A_CUR_ADDR   = 8'hFE;
   // control register fields
   localparam int ADX_CN_RUN    = 7;
   localparam int ADX_CN_DONE   = 6;
   localparam int ADX_CN_MODE   = 5;
   localparam int ADX_CN_ERR_B  = 4;
   localparam int ADX_CN_ERR_A  = 3;
   localparam int ADX_CN_WARNEN = 2;
   localparam int ADX_CN_WARN_B = 1;
   localparam int ADX_CN_WARN_A = 0;
   // configuration register fields
   localparam int ADX_CF_GRANT  = 7;
   localparam int ADX_CF_BUSY   = 6;
   localparam int ADX_CF_RPTEN  = 3;
   localparam int ADX_CF_RPT    = 2;
   localparam int ADX_CF_EOEN   = 1;
   localparam int ADX_CF_EO     = 0;
   // instruction word fields
   localparam int ADX_I_CONT    = 7;
   localparam int ADX_I_DIFF    = 6;
   localparam int ADX_I_B       = 5;
   localparam int ADX_I_A       = 4;
   // reset values and sizes
   localparam logic [7:0]  ADX_RST_BYTE  = 8'h00;
   localparam logic [15:0] ADX_RST_WORD  = 16'h0000;
   localparam int          ADX_IBUF_WORDS = 64;
   localparam int          ADX_IADDR_W    = 6;
   localparam logic [15:0] ADX_STEP_WORD = 16'h0002;
   localparam logic [15:0] ADX_ONCHIP_TOP = 16'h1000;
   // sequencer states
   typedef enum logic [2:0] {
      ADX_IDLE   = 3'b000,
      ADX_FETCH  = 3'b001,
      ADX_DECODE = 3'b010,
      ADX_WR_A   = 3'b011,
      ADX_WR_B   = 3'b100,
      ADX_STEP   = 3'b101
   } adx_state_e;
endpackage

/* File: design/adx_ibuf.sv */
// instruction buffer storage, one port, registered read data
`timescale 1ns/1ps
module adx_ibuf #(
   parameter int WORDS  = 64,
   parameter int ADDR_W = 6
) (
   input  wire logic              CLK,
   input  wire logic              WE,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [7:0]        WDATA,
   output logic      [7:0]        RDATA
);
   logic [7:0] mem [WORDS];

   // no reset on the array: contents after reset are undefined on purpose
   always_ff @(posedge CLK) begin
      if (WE) begin
         mem[ADDR] <= WDATA;
      end
      RDATA <= mem[ADDR];
   end
endmodule

/* File: tb/adx_far_side.sv */
// data ram model on the far side of the transfer engine
`timescale 1ns/1ps
module adx_far_side #(
   parameter int LAT = 3
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        RAM_WR_REQ,
   input  wire logic [15:0] RAM_ADDR,
   input  wire logic [15:0] RAM_WDATA,
   output logic             RAM_WR_ACK,
   output logic      [15:0] last_addr,
   output logic      [15:0] last_data,
   output int               wr_count
);
   int wait_q;
   // slow ram: ack only after lat+1 cycles, so the engine must hold its request
   always_ff @(posedge CLK) begin
      if (RST) begin
         wait_q <= 0;
         RAM_WR_ACK <= 1'b0;
         wr_count <= 0;
      end else if (RAM_WR_REQ && !RAM_WR_ACK) begin
         if (wait_q == LAT) begin
            RAM_WR_ACK <= 1'b1;
            wait_q <= 0;
            last_addr <= RAM_ADDR;
            last_data <= RAM_WDATA;
            wr_count <= wr_count + 1;
         end else begin
            wait_q <= wait_q + 1;
         end
      end else begin
         RAM_WR_ACK <= 1'b0; // one-cycle ack pulse
      end
   end
endmodule

/* File: tb/adx_dma_ctrl_bench.sv */
// self-checking bench for the transfer engine control block
`timescale 1ns/1ps
module adx_dma_ctrl_bench;
   import adx_pkg::*;
   logic CLK, RST, SFR_WR, SFR_RD, ADC_A_DONE, ADC_B_DONE;
   logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, v;
   logic [15:0] ADC_A_DATA, ADC_B_DATA, RAM_ADDR, RAM_WDATA, la, ld;
   logic RAM_WR_REQ, RAM_OFFCHIP, RAM_WR_ACK, DMA_IRQ;
   int bad_count, checks, cyc, wrn;
   adx_dma_ctrl u_adx_dma_ctrl (.CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
      .SFR_RDATA(SFR_RDATA), .ADC_A_DONE(ADC_A_DONE),
      .ADC_A_DATA(ADC_A_DATA), .ADC_B_DONE(ADC_B_DONE),
      .ADC_B_DATA(ADC_B_DATA), .RAM_WR_REQ(RAM_WR_REQ),
      .RAM_OFFCHIP(RAM_OFFCHIP), .RAM_ADDR(RAM_ADDR),
      .RAM_WDATA(RAM_WDATA), .RAM_WR_ACK(RAM_WR_ACK), .DMA_IRQ(DMA_IRQ));
   adx_far_side u_adx_far_side (.CLK(CLK), .RST(RST),
      .RAM_WR_REQ(RAM_WR_REQ), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
      .RAM_WR_ACK(RAM_WR_ACK), .last_addr(la), .last_data(ld),
      .wr_count(wrn));
   //////////////////////////////////////////////////////////////////////
   // clock, and a cycle ceiling so a hang still reaches the verdict
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes; read data is taken the cycle after the read edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      SFR_WR <= 1'b1; SFR_ADDR <= a; SFR_WDATA <= d;
      @(posedge CLK);
      SFR_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      SFR_RD <= 1'b1; SFR_ADDR <= a;
      @(posedge CLK);
      SFR_RD <= 1'b0;
      #1 v = SFR_RDATA;
   endtask
   task automatic adc_a(input logic [15:0] d);
      @(posedge CLK);
      ADC_A_DONE <= 1'b1; ADC_A_DATA <= d;
      @(posedge CLK);
      ADC_A_DONE <= 1'b0;
   endtask
   // both converters finish together, one pulse each
   task automatic adc_ab(input logic [15:0] da, input logic [15:0] db);
      @(posedge CLK);
      ADC_A_DONE <= 1'b1;
      ADC_A_DATA <= da;
      ADC_B_DONE <= 1'b1;
      ADC_B_DATA <= db;
      @(posedge CLK);
      ADC_A_DONE <= 1'b0;
      ADC_B_DONE <= 1'b0;
   endtask
   task automatic wait_wr(input int n);
      for (int i = 0; i < 200 && wrn < n; i++) @(posedge CLK);
      chk(16'(wrn), 16'(n));
   endtask
   task automatic wait_idle();
      rd(ADX_A_CONTROL);
      for (int i = 0; i < 50 && v[7] !== 1'b0; i++) rd(ADX_A_CONTROL);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {SFR_WR, SFR_RD, ADC_A_DONE, ADC_B_DONE} = 4'h0;
      {SFR_ADDR, SFR_WDATA} = 16'h0000;
      {ADC_A_DATA, ADC_B_DATA} = 32'h0000_0000;
      {bad_count, checks, cyc} = '0;
      RST = 1'b1;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      rd(ADX_A_CONTROL); chk(v, 8'h00);
      // program: collect A, then end of operation; low bits kept zero
      wr(ADX_A_IPTR, 8'h00);
      wr(ADX_A_IDATA, 8'h10);
      wr(ADX_A_IDATA, 8'h00);
      rd(ADX_A_IPTR); chk(v, 8'h02);
      wr(ADX_A_IPTR, 8'h00);
      rd(ADX_A_IDATA); chk(v, 8'h10);
      rd(ADX_A_IPTR); chk(v, 8'h01);
      wr(ADX_A_BEGIN_LO, 8'h00); wr(ADX_A_BEGIN_HI, 8'h01);
      wr(ADX_A_LIMIT_LO, 8'h01); wr(ADX_A_LIMIT_HI, 8'h00);
      wr(ADX_A_BOUNDARY, 8'h00);
      wr(ADX_A_CONTROL, 8'h80);
      rd(ADX_A_CONTROL); chk(v[7], 1'b1);
      adc_a(16'h1234);
      wait_wr(1);
      chk(la, 16'h0100);
      chk(ld, 16'h1234);
      wait_idle();
      chk(v, 8'h40);
      rd(ADX_A_CONFIG); chk(v, 8'h05);
      chk(DMA_IRQ, 1'b1);
      repeat (5) @(posedge CLK);
      rd(ADX_A_CONTROL); chk(v, 8'h40);
      // end-of-op flag alone stays quiet until its enable is set
      wr(ADX_A_CONTROL, 8'h00);
      #1 chk(DMA_IRQ, 1'b0);
      wr(ADX_A_CONFIG, 8'h07);
      #1 chk(DMA_IRQ, 1'b1);
      wr(ADX_A_CONFIG, 8'h00);
      #1 chk(DMA_IRQ, 1'b0);
      // off-chip target held by cpu grant: words pile up and overflow
      wr(ADX_A_BEGIN_HI, 8'h20);
      wr(ADX_A_CONFIG, 8'h80);
      wr(ADX_A_CONTROL, 8'h80);
      adc_a(16'h1111);
      adc_a(16'h2222);
      rd(ADX_A_CONTROL); chk(v, 8'h81);
      chk(DMA_IRQ, 1'b0);
      adc_a(16'h3333);
      rd(ADX_A_CONTROL); chk(v, 8'h89);
      chk(DMA_IRQ, 1'b1);
      chk(RAM_OFFCHIP, 1'b1);
      // held off by the grant, so no off-chip access is in progress
      rd(ADX_A_CONFIG); chk(v, 8'h80);
      repeat (8) @(negedge CLK) chk(RAM_WR_REQ, 1'b0);
      wr(ADX_A_CONFIG, 8'h00);
      // released: the first buffered word is now being written off-chip
      rd(ADX_A_CONFIG); chk(v, 8'h40);
      wait_wr(2);
      chk(la, 16'h2000);
      chk(ld, 16'h1111);
      wait_idle();
      // reset again once idle; a stale buffered word must not survive it
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      rd(ADX_A_CONTROL); chk(v, 8'h00);
      // mode 1: A and B words per pass, two passes, then end of operation
      wr(ADX_A_IPTR, 8'h02);
      wr(ADX_A_IDATA, 8'h30);
      wr(ADX_A_IDATA, 8'h00);
      wr(ADX_A_BEGIN_HI, 8'h03);
      wr(ADX_A_LIMIT_LO, 8'h02);
      wr(ADX_A_BOUNDARY, 8'h02);
      wr(ADX_A_CONTROL, 8'hA0);
      adc_ab(16'hA001, 16'hB001);
      wait_wr(2);
      chk(la, 16'h0302);
      chk(ld, 16'hB001);
      adc_ab(16'hA002, 16'hB002);
      wait_wr(4);
      chk(la, 16'h0306);
      chk(ld, 16'hB002);
      wait_idle();
      chk(v, 8'h60);
      rd(ADX_A_CONFIG); chk(v, 8'h05);
      rd(ADX_A_COUNT_LO); chk(v, 8'h02);
      rd(ADX_A_CUR_ADDR); chk(v, 8'h02);
      tally_and_finish();
   end
endmodule
